// *** src/pee_pkg.sv ***
// Functional notes
// [RULE1] Device drives data only with write enable high, chip and output enables low.
// [RULE2] Device floats data whenever chip enable or output enable is high.
// [RULE3] Write needs chip and write enables low with output enable high.
// [RULE4] Address is captured on the later falling edge of the two strobes.
// [RULE5] Data is captured on the earlier rising edge of the two strobes.
// [RULE6] A byte write erases and programs itself within the program cycle time.
// [RULE7] Strobes shorter than the glitch threshold start no write.
// [RULE8] Page mode takes one to sixty-four bytes in one program cycle.
// [RULE9] Each page strobe loads address and data into a 64-byte buffer.
// [RULE10] Page number from upper address bits is captured on the last falling edge.
// [RULE11] Low six address bits pick the byte in the page, any order.
// [RULE12] Host starts each load within the byte load interval, not sooner than minimum.
// [RULE13] A page sequence may be any length if loads keep within the interval.
// [RULE14] Device restarts the byte load timer on each write enable rising edge.
// [RULE15] Write enable falling stops the timer; expiry starts programming.
// [RULE16] Host ends a page by holding write enable high past the interval.
// [RULE17] Programming erases each addressed cell, then writes it.
// [RULE18] A page write changes only the loaded bytes.
// [RULE19] Writes are ignored for the lockout period after power-up.
// [RULE20] During programming, reading the last byte returns inverted bit seven.
// [RULE21] During programming, consecutive reads show bit six toggling.
// [RULE22] During programming the device takes no loads and answers only status.
package pee_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 64;
    localparam int CLK_MHZ = 100;
    localparam int STROBE_NS = 120;
    localparam int READ_NS = 150;
    localparam int BLC_MIN_NS = 100;
    localparam int BLC_MAX_US = 100;
    localparam int LOCKOUT_MS = 10;
    localparam int PROG_MS = 5;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int BLC_MIN_CYC = (BLC_MIN_NS * CLK_MHZ + 999) / 1000;
    // Gap kept below the load interval maximum, rounded down.
    localparam int BLC_GAP_CYC = (BLC_MAX_US * CLK_MHZ) / 2;
    // End-of-page hold is past the maximum interval, with margin.
    localparam int BLC_END_CYC = BLC_MAX_US * CLK_MHZ + 100;
    localparam int LOCKOUT_CYC = LOCKOUT_MS * 1000 * CLK_MHZ;
    localparam int PROG_CYC = PROG_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;
    localparam int BITS_W = 7;
    localparam logic [5:0] STEP_CE = 6'h01;
endpackage

// *** src/pee_delay.sv ***
`timescale 1ns/1ns
`default_nettype none
// Loadable down counter; done is high while the count is zero.
module pee_delay (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic load,
    input wire logic [pee_pkg::CNT_W-1:0] value,
    output logic done
);
    import pee_pkg::*;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = value;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    // Done does not look at load, so callers that load on done form no loop.
    assign done = (cnt_r == '0);
endmodule
`default_nettype wire

// *** src/pee_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host controller for the parallel EEPROM. The user issues a read, or a page
// write of 1..64 bytes handed over one byte at a time, then waits for done.
module pee_host #(
    parameter int LOCKOUT_CYCLES = pee_pkg::LOCKOUT_CYC,
    parameter int BLC_END_CYCLES = pee_pkg::BLC_END_CYC,
    parameter int BLC_GAP_CYCLES = pee_pkg::BLC_GAP_CYC,
    parameter int PROG_CYCLES = pee_pkg::PROG_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // User read request
    input wire logic rd_req,
    input wire logic [pee_pkg::ADDR_W-1:0] rd_addr,
    output logic [pee_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    // User write stream; wr_last marks the final byte of a page
    input wire logic wr_valid,
    input wire logic [pee_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [pee_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_last,
    output logic wr_ready,
    output logic wr_done,
    output logic busy,
    // Device pins
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [pee_pkg::ADDR_W-1:0] address_lines,
    output logic [pee_pkg::DATA_W-1:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic [pee_pkg::DATA_W-1:0] data_lines_i
);
    import pee_pkg::*;

    typedef enum logic [7:0] {
        S_LOCK = 8'h01,
        S_IDLE = 8'h02,
        S_RD = 8'h04,
        S_WLOW = 8'h08,
        S_WGAP = 8'h10,
        S_WEND = 8'h20,
        S_POLL = 8'h40,
        S_PGAP = 8'h80
    } pee_state_type;

    pee_state_type st_r, st_nxt;
    logic ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, doe_r, doe_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt, last_addr_r, last_addr_nxt;
    logic [DATA_W-1:0] dout_r, dout_nxt, last_data_r, last_data_nxt, rdat_r, rdat_nxt;
    logic rvalid_r, rvalid_nxt, wdone_r, wdone_nxt, last_r, last_nxt;
    logic [BITS_W-1:0] step_r, step_nxt;
    logic [ADDR_W-6-1:0] page_r, page_nxt;
    logic [DATA_W-1:0] din_s1_r, din_s2_r;
    logic tmr_load, tmr_done;
    logic [CNT_W-1:0] tmr_val;
    logic boot_r;

    pee_delay u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .value(tmr_val),
        .done(tmr_done)
    );

    // Data lines come from another timing domain and pass two flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            din_s1_r <= data_lines_i;
            din_s2_r <= din_s1_r;
        end
    end

    // Ready is exactly the condition under which a byte is taken below.
    assign wr_ready = (st_r == S_IDLE && tmr_done) || (st_r == S_WGAP && step_r >= BITS_W'(BLC_MIN_CYC));

    always_comb begin
        st_nxt = st_r;
        ce_n_nxt = ce_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        doe_nxt = doe_r;
        addr_nxt = addr_r;
        dout_nxt = dout_r;
        last_addr_nxt = last_addr_r;
        last_data_nxt = last_data_r;
        rdat_nxt = rdat_r;
        rvalid_nxt = 1'b0;
        wdone_nxt = 1'b0;
        last_nxt = last_r;
        step_nxt = step_r;
        page_nxt = page_r;
        tmr_load = 1'b0;
        tmr_val = '0;
        unique case (st_r)
            S_LOCK: begin
                // No write is offered until the power-up lockout is over.
                if (boot_r) begin
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(LOCKOUT_CYCLES);
                end else if (tmr_done) begin // see [RULE19]
                    st_nxt = S_IDLE;
                end
            end
            S_IDLE: begin
                if (wr_valid && tmr_done) begin
                    // Write: ce and we low, oe high, data driven. see [RULE3]
                    addr_nxt = wr_addr;
                    dout_nxt = wr_data;
                    page_nxt = wr_addr[ADDR_W-1:6]; // see [RULE10]
                    last_nxt = wr_last;
                    oe_n_nxt = 1'b1;
                    doe_nxt = 1'b1;
                    ce_n_nxt = 1'b0;
                    we_n_nxt = 1'b0; // see [RULE4]
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(STROBE_CYC); // see [RULE7]
                    st_nxt = S_WLOW;
                end else if (rd_req && tmr_done) begin
                    addr_nxt = rd_addr;
                    doe_nxt = 1'b0;
                    we_n_nxt = 1'b1;
                    ce_n_nxt = 1'b0;
                    oe_n_nxt = 1'b0; // see [RULE1]
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(READ_CYC + 2);
                    st_nxt = S_RD;
                end
            end
            S_RD: begin
                if (tmr_done) begin
                    rdat_nxt = din_s2_r;
                    rvalid_nxt = 1'b1;
                    ce_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1; // see [RULE2]
                    st_nxt = S_IDLE;
                end
            end
            S_WLOW: begin
                if (tmr_done) begin
                    // Rising we latches data; data held one more cycle. see [RULE5]
                    we_n_nxt = 1'b1;
                    ce_n_nxt = 1'b1;
                    last_addr_nxt = addr_r;
                    last_data_nxt = dout_r;
                    tmr_load = 1'b1;
                    tmr_val = last_r ? CNT_W'(BLC_END_CYCLES) : CNT_W'(BLC_GAP_CYCLES);
                    st_nxt = last_r ? S_WEND : S_WGAP; // see [RULE9]
                end
            end
            S_WGAP: begin
                doe_nxt = 1'b0;
                // Next load must come within the interval; a late source aborts
                // the page and lets the device program what it holds. see [RULE12]
                if (wr_valid && wr_ready) begin
                    addr_nxt = {page_r, wr_addr[5:0]}; // see [RULE11]
                    dout_nxt = wr_data;
                    last_nxt = wr_last;
                    oe_n_nxt = 1'b1;
                    doe_nxt = 1'b1;
                    ce_n_nxt = 1'b0;
                    we_n_nxt = 1'b0; // see [RULE13]
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(STROBE_CYC);
                    st_nxt = S_WLOW;
                end else if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(BLC_END_CYCLES - BLC_GAP_CYCLES);
                    st_nxt = S_WEND;
                end
                if (step_r != '1) begin
                    step_nxt = step_r + 1'b1;
                end
            end
            S_WEND: begin
                doe_nxt = 1'b0;
                // we held high past the interval starts programming. see [RULE16]
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(PROG_CYCLES); // see [RULE6]
                    st_nxt = S_POLL;
                end
            end
            S_POLL: begin
                // Poll the last byte until bit seven matches the data written, or the program timeout ends. see [RULE20]
                addr_nxt = last_addr_r;
                ce_n_nxt = 1'b0;
                oe_n_nxt = 1'b0;
                step_nxt = '0;
                st_nxt = S_PGAP;
            end
            S_PGAP: begin
                step_nxt = step_r + 1'b1;
                if (step_r == BITS_W'(READ_CYC + 2)) begin
                    ce_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    if (din_s2_r[DATA_W-1] == last_data_r[DATA_W-1] || tmr_done) begin
                        wdone_nxt = 1'b1; // see [RULE22]
                        // Clear the program timeout so idle takes requests at once.
                        tmr_load = 1'b1;
                        st_nxt = S_IDLE;
                    end else begin
                        st_nxt = S_POLL;
                    end
                end
            end
            default: st_nxt = S_LOCK;
        endcase
        if (st_r == S_WLOW && tmr_done) begin
            step_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_LOCK;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            doe_r <= 1'b0;
            addr_r <= '0;
            dout_r <= '0;
            last_addr_r <= '0;
            last_data_r <= '0;
            rdat_r <= '0;
            rvalid_r <= 1'b0;
            wdone_r <= 1'b0;
            last_r <= 1'b0;
            step_r <= '0;
            page_r <= '0;
        end else begin
            st_r <= st_nxt;
            ce_n_r <= ce_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            doe_r <= doe_nxt;
            addr_r <= addr_nxt;
            dout_r <= dout_nxt;
            last_addr_r <= last_addr_nxt;
            last_data_r <= last_data_nxt;
            rdat_r <= rdat_nxt;
            rvalid_r <= rvalid_nxt;
            wdone_r <= wdone_nxt;
            last_r <= last_nxt;
            step_r <= step_nxt;
            page_r <= page_nxt;
        end
    end

    // The lockout timer is loaded once, right after reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_r <= 1'b1;
        end else begin
            boot_r <= 1'b0;
        end
    end

    assign ce_n = ce_n_r;
    assign oe_n = oe_n_r;
    assign we_n = we_n_r;
    assign address_lines = addr_r;
    assign data_lines_o = dout_r;
    assign data_lines_oe = doe_r;
    assign rd_data = rdat_r;
    assign rd_valid = rvalid_r;
    assign wr_done = wdone_r;
    assign busy = (st_r != S_IDLE);

    property p_no_contention;
        @(posedge clk) disable iff (!rst_n) data_lines_oe |-> oe_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("driving with oe low"); // see [RULE2]
    property p_write_strobe;
        @(posedge clk) disable iff (!rst_n) !we_n |-> (!ce_n && oe_n && data_lines_oe);
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("bad write strobe"); // see [RULE3]
    property p_strobe_width;
        @(posedge clk) disable iff (!rst_n) $fell(we_n) |-> !we_n [*8];
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe too short"); // see [RULE7]
    property p_data_hold;
        @(posedge clk) disable iff (!rst_n) $rose(we_n) |-> data_lines_oe && $stable(data_lines_o);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data not held"); // see [RULE5]
    property p_addr_stable;
        @(posedge clk) disable iff (!rst_n) !we_n && $past(!we_n) |-> $stable(address_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in strobe"); // see [RULE4]
    property p_lock;
        @(posedge clk) disable iff (!rst_n) st_r == S_LOCK |-> we_n;
    endproperty
    a_lock: assert property (p_lock) else $error("write during lockout"); // see [RULE19]
    property p_read_pins;
        @(posedge clk) disable iff (!rst_n) !oe_n |-> we_n && !ce_n && !data_lines_oe;
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("bad read pins"); // see [RULE1]
    property p_page_same;
        @(posedge clk) disable iff (!rst_n)
            $fell(we_n) && st_r == S_WLOW && $past(st_r) == S_WGAP
            |-> address_lines[ADDR_W-1:6] == page_r;
    endproperty
    a_page_same: assert property (p_page_same) else $error("page changed"); // see [RULE10]
    c_write: cover property (@(posedge clk) disable iff (!rst_n) $rose(wr_done));
    c_read: cover property (@(posedge clk) disable iff (!rst_n) $rose(rd_valid));
    c_page: cover property (@(posedge clk) disable iff (!rst_n)
        st_r == S_WGAP ##1 st_r == S_WLOW);
endmodule
`default_nettype wire

// *** tb/pee_dev_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Behavioural parallel EEPROM; timers count clock cycles of the host.
module pee_dev_model #(
    parameter int BLC_CYC = 150,
    parameter int PROG_CYC = 300,
    parameter int LOCK_CYC = 250,
    parameter int GLITCH_CYC = 2,
    parameter int MIN_CYC = 10
) (
    // Clock on whose falling edge the pins are sampled and time is measured
    input wire logic clk,
    // Device pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [pee_pkg::ADDR_W-1:0] address_lines,
    input wire logic [pee_pkg::DATA_W-1:0] bus_in,
    output logic [pee_pkg::DATA_W-1:0] dev_q,
    output logic dev_oe,
    // Observation
    output logic prog,
    output var int viol
);
    import pee_pkg::*;
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] pbuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pval = '0;
    logic [ADDR_W-1:0] a_lat = '0;
    logic [8:0] pg = '0;
    logic [7:0] d_lat = '0;
    logic [7:0] last_d = '0;
    logic wr_act = 0, rd_act = 0, tog = 0, loading = 0;
    int wcnt = 0, blc = 0, pcnt = 0, lock = 0, gap = 0;
    wire wr_now = !ce_n && !we_n && oe_n;
    wire rd_now = !ce_n && !oe_n && we_n;
    initial begin
        prog = 0;
        viol = 0;
        for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 8'hff;
    end
    always_comb begin
        dev_oe = rd_now;
        dev_q = prog ? {~last_d[7], tog, ~last_d[5:0]} : mem[address_lines];
    end
    always @(negedge clk) begin
        if (lock < LOCK_CYC) lock++;
        gap++;
        if (wr_now && !wr_act) begin
            a_lat = address_lines;
            wcnt = 0;
        end
        if (wr_now) begin
            d_lat = bus_in;
            wcnt++;
        end
        if (!wr_now && wr_act && wcnt >= GLITCH_CYC && lock >= LOCK_CYC) begin
            if (prog) begin
                viol++;
            end else begin
                if (loading && gap < MIN_CYC) viol++;
                pbuf[a_lat[5:0]] = d_lat;
                pval[a_lat[5:0]] = 1'b1;
                pg = a_lat[14:6];
                last_d = d_lat;
                loading = 1;
                gap = 0;
                // Each load restarts the byte load timer from zero.
                blc = 0;
            end
        end
        if (loading) begin
            if (!we_n) blc = 0;
            else blc++;
            if (blc >= BLC_CYC) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (pval[i]) mem[{pg, i[5:0]}] = 8'hff;
                end
                loading = 0;
                prog = 1;
                pcnt = 0;
            end
        end else if (prog) begin
            pcnt++;
            if (pcnt >= PROG_CYC) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (pval[i]) mem[{pg, i[5:0]}] = pbuf[i];
                end
                pval = '0;
                prog = 0;
            end
        end
        if (rd_now && !rd_act) tog = ~tog;
        rd_act = rd_now;
        wr_act = wr_now;
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pee_pkg::*;
    localparam int LOCK_H = 300;
    logic clk = 0;
    logic rst_n = 0;
    logic rd_req = 0;
    logic wr_valid = 0;
    logic wr_last = 0;
    logic [ADDR_W-1:0] rd_addr = '0;
    logic [ADDR_W-1:0] wr_addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic [DATA_W-1:0] last_bus = '0;
    logic [DATA_W-1:0] exp_m [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rd_data, data_lines_o, dev_q, bus;
    logic [ADDR_W-1:0] address_lines;
    logic rd_valid, wr_ready, wr_done, busy, ce_n, oe_n, we_n, data_lines_oe, dev_oe, prog;
    int viol;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    // A released bus shows the inverse of its last level, never a held value.
    assign bus = data_lines_oe ? data_lines_o : (dev_oe ? dev_q : ~last_bus);
    always @(posedge clk) last_bus <= bus;
    pee_host #(.LOCKOUT_CYCLES(LOCK_H), .BLC_END_CYCLES(200), .BLC_GAP_CYCLES(50),
        .PROG_CYCLES(500)) pee_host_i (.clk, .rst_n, .rd_req, .rd_addr, .rd_data, .rd_valid,
        .wr_valid, .wr_addr, .wr_data, .wr_last, .wr_ready, .wr_done, .busy, .ce_n, .oe_n,
        .we_n, .address_lines, .data_lines_o, .data_lines_oe, .data_lines_i(bus));
    pee_dev_model pee_dev_model_i (.clk, .ce_n, .oe_n, .we_n, .address_lines, .bus_in(bus),
        .dev_q, .dev_oe, .prog, .viol);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic l);
        int n;
        n = 0;
        wr_addr = a;
        wr_data = d;
        wr_last = l;
        wr_valid = 1;
        while (wr_ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk("wr_ready", 8'h01, {7'h00, wr_ready});
        @(negedge clk);
        wr_valid = 0;
        exp_m[a] = d;
        @(negedge clk);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (wr_done !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("wr_done", 8'h01, {7'h00, wr_done});
        chk("prog", 8'h00, {7'h00, prog});
        chk("busy", 8'h00, {7'h00, busy});
    endtask
    task automatic rd(input logic [14:0] a);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        rd_addr = a;
        rd_req = 1;
        @(negedge clk);
        rd_req = 0;
        while (rd_valid !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("rd_valid", 8'h01, {7'h00, rd_valid});
        chk("rd_data", exp_m[a], rd_data);
    endtask
    // Started inside the lockout, so the host must hold the byte back.
    task automatic t_byte;
        wr(15'h0100, 8'ha5, 1'b1);
        wait_done;
        rd(15'h0100);
        wr(15'h0100, 8'h5a, 1'b1);
        wait_done;
        rd(15'h0100);
    endtask
    task automatic t_page;
        wr(15'h0085, 8'h11, 1'b0);
        wr(15'h0081, 8'h22, 1'b0);
        wr(15'h00bf, 8'h33, 1'b0);
        wr(15'h0080, 8'h44, 1'b1);
        wait_done;
        for (int i = 0; i < 64; i++) rd(15'h0080 + 15'(i));
    endtask
    task automatic t_full;
        for (int i = 0; i < 64; i++) wr({9'h1ff, 6'(i)}, 8'(i) ^ 8'h3c, i == 63);
        wait_done;
        for (int i = 0; i < 64; i++) rd({9'h1ff, 6'(i)});
    endtask
    always @(negedge clk) begin
        cyc++;
        if (cyc < 16 + LOCK_H && we_n === 1'b0) chk("we_n", 8'h01, 8'h00);
        if (data_lines_oe & dev_oe) chk("contention", 8'h00, 8'h01);
        if (cyc == 40000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) exp_m[i] = 8'hff;
        repeat (16) @(negedge clk);
        rst_n = 1;
        t_byte;
        t_page;
        t_full;
        chk("viol", 8'h00, viol[7:0]);
        close_out;
    end
endmodule
`default_nettype wire
